//--- rtl/atc_core.sv
// Analog comparator and threshold trigger evaluation with register port
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
`include "atc_regs.svh"
module atc_core
  import atc_pkg::*;
#(
  parameter int NUM_AIN = 8,
  parameter int NUM_AOUT = 2,
  parameter int WIDE_W = 32
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cycle_tick,
  input wire logic [NUM_AIN*16-1:0] i_analog_channels,
  input wire logic [NUM_AOUT*16-1:0] i_analog_outputs,
  input wire logic signed [31:0] i_ext_on,
  input wire logic signed [31:0] i_ext_off,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_q,
  output logic signed [31:0] o_actual,
  output logic o_done
);

  localparam int NSRC = NUM_AIN + NUM_AOUT;

  // ===========================================================
  // Helpers
  function automatic logic signed [15:0] clamp16(input logic signed [15:0] v, input logic [15:0] lim);
    logic signed [15:0] l;
    l = $signed(lim);
    if (v > l)
      clamp16 = l;
    else if (v < -l)
      clamp16 = -l;
    else
      clamp16 = v;
  endfunction : clamp16

  function automatic logic signed [15:0] pick(input logic [3:0] sel, input logic [NSRC*16-1:0] all);
    logic signed [15:0] raw;
    raw = 16'sh0000;
    for (int k = 0; k < NSRC; k++)
      if (sel == 4'(k))
        raw = $signed(all[k*16 +: 16]);
    pick = raw;
  endfunction : pick

  // ===========================================================
  // Registers
  logic [15:0] ctrl;
  logic signed [15:0] gain;
  logic signed [15:0] offs;
  logic signed [15:0] thr_on;
  logic signed [15:0] thr_off;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ctrl <= `ATC_CTRL_RST;
      gain <= `ATC_GAIN_RST;
      offs <= `ATC_OFFS_RST;
      thr_on <= `ATC_ON_RST;
      thr_off <= `ATC_OFF_RST;
    end
    else if (i_wr)
    begin
      if (i_addr == `ATC_CTRL_ADDR)
        ctrl <= i_wdata;
      else if (i_addr == `ATC_GAIN_ADDR)
        gain <= clamp16($signed(i_wdata), `ATC_GAIN_MAX);
      else if (i_addr == `ATC_OFFS_ADDR)
        offs <= clamp16($signed(i_wdata), `ATC_OFFS_MAX);
      else if (i_addr == `ATC_ON_ADDR)
        thr_on <= clamp16($signed(i_wdata), `ATC_THR_MAX);
      else if (i_addr == `ATC_OFF_ADDR)
        thr_off <= clamp16($signed(i_wdata), `ATC_THR_MAX);
    end
  end

  atc_mode_t mode;
  logic [3:0] sel_a;
  logic [3:0] sel_b;
  assign mode = atc_mode_t'(ctrl[`ATC_CTRL_MODE_BIT]);
  assign sel_a = ctrl[`ATC_CTRL_SELA_LSB +: 4];
  assign sel_b = ctrl[`ATC_CTRL_SELB_LSB +: 4];

  // ===========================================================
  // Source selection and scaling
  logic [NSRC*16-1:0] all_src;
  logic signed [15:0] first_analog_in;
  logic signed [15:0] second_analog_in;
  logic signed [WIDE_W-1:0] scaled_a;
  logic signed [WIDE_W-1:0] scaled_b;

  // Channels carry 0..1000 for 0..10 V; outputs follow them
  assign all_src = {i_analog_outputs, i_analog_channels};
  assign first_analog_in = pick(sel_a, all_src);
  assign second_analog_in = pick(sel_b, all_src);

  atc_scaler #(.IN_W(16), .OUT_W(WIDE_W)) u_scale_a
  (
    .i_raw(first_analog_in),
    .i_gain(gain),
    .i_offset(offs),
    .o_value(scaled_a)
  );

  atc_scaler #(.IN_W(16), .OUT_W(WIDE_W)) u_scale_b
  (
    .i_raw(second_analog_in),
    .i_gain(gain),
    .i_offset(offs),
    .o_value(scaled_b)
  );

  // ===========================================================
  // Evaluation sequence
  atc_state_t state;
  logic signed [WIDE_W-1:0] act_a;
  logic signed [WIDE_W-1:0] act_b;
  logic signed [WIDE_W-1:0] cmp_val;
  logic signed [WIDE_W-1:0] eff_on;
  logic signed [WIDE_W-1:0] eff_off;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state <= ATC_IDLE;
    else
    begin
      case (state)
        ATC_IDLE:
          if (i_cycle_tick)
            state <= ATC_SCALE;
        ATC_SCALE:
          state <= ATC_DECIDE;
        default:
          state <= ATC_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      act_a <= '0;
      act_b <= '0;
      cmp_val <= '0;
      eff_on <= '0;
      eff_off <= '0;
    end
    else if (state == ATC_SCALE)
    begin
      act_a <= scaled_a;
      act_b <= scaled_b;
      if (mode == ATC_MODE_COMPARE)
        cmp_val <= scaled_a - scaled_b;
      else
        cmp_val <= scaled_a;
      // Decimals field never enters here
      eff_on <= ctrl[`ATC_CTRL_ONSRC_BIT] ? WIDE_W'(i_ext_on) : WIDE_W'(thr_on);
      eff_off <= ctrl[`ATC_CTRL_OFFSRC_BIT] ? WIDE_W'(i_ext_off) : WIDE_W'(thr_off);
    end
  end

  // ===========================================================
  // Decision
  logic next_q;
  logic hyst;
  assign hyst = (eff_on >= eff_off);

  always_comb
  begin
    next_q = o_q;
    if (hyst)
    begin
      if (cmp_val > eff_on)
        next_q = 1'b1;
      else if (cmp_val <= eff_off)
        next_q = 1'b0;
      else
        next_q = o_q;
    end
    else
      next_q = (cmp_val >= eff_on) && (cmp_val < eff_off);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_q <= 1'b0;
    else if (state == ATC_DECIDE)
      o_q <= next_q;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_done <= 1'b0;
      o_actual <= '0;
    end
    else
    begin
      o_done <= (state == ATC_DECIDE);
      if (state == ATC_DECIDE)
        o_actual <= 32'(cmp_val);
    end
  end

  // ===========================================================
  // Read port
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_rdata <= 16'h0000;
    else if (i_rd)
    begin
      if (i_addr == `ATC_CTRL_ADDR)
        o_rdata <= ctrl;
      else if (i_addr == `ATC_GAIN_ADDR)
        o_rdata <= gain;
      else if (i_addr == `ATC_OFFS_ADDR)
        o_rdata <= offs;
      else if (i_addr == `ATC_ON_ADDR)
        o_rdata <= thr_on;
      else if (i_addr == `ATC_OFF_ADDR)
        o_rdata <= thr_off;
      else if (i_addr == `ATC_STAT_ADDR)
        o_rdata <= {14'h0000, hyst, o_q};
      else if (i_addr == `ATC_ACT_ADDR)
        o_rdata <= act_a[15:0];
      else if (i_addr == `ATC_REF_ADDR)
        o_rdata <= act_b[15:0];
      else if (i_addr == `ATC_DIFF_ADDR)
        o_rdata <= cmp_val[15:0];
      else
        o_rdata <= 16'h0000;
    end
    else
      o_rdata <= 16'h0000;
  end

  // ===========================================================
  // Checks
  sequence tick_s;
    i_cycle_tick && state == ATC_IDLE;
  endsequence

  sequence eval_s;
    ##1 (state == ATC_SCALE) ##1 (state == ATC_DECIDE);
  endsequence

  property cycle_flow_p;
    @(posedge i_clk) disable iff (i_sys_rst) tick_s |-> eval_s ##1 o_done;
  endproperty

  cycle_flow_a: assert property (cycle_flow_p) else $error("evaluation did not finish in three cycles");

  hyst_set_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_DECIDE && hyst && cmp_val > eff_on) |=> o_q)
    else $error("output not set above on");

  hyst_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_DECIDE && hyst && cmp_val <= eff_off) |=> !o_q)
    else $error("output not cleared");

  hyst_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_DECIDE && hyst && cmp_val > eff_off && cmp_val <= eff_on) |=> $stable(o_q))
    else $error("output changed in band");

  window_out_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_DECIDE && !hyst) |=>
    o_q == (($past(cmp_val) >= $past(eff_on)) && ($past(cmp_val) < $past(eff_off))))
    else $error("window output wrong");

  window_low_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_DECIDE && !hyst && cmp_val < eff_on) |=> !o_q)
    else $error("output high below window");

  q_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state != ATC_DECIDE) |=> $stable(o_q))
    else $error("output moved outside decide");

  diff_form_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_SCALE && mode == ATC_MODE_COMPARE) |=> cmp_val == act_a - act_b)
    else $error("difference not first minus second");

  done_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_done |=> !o_done)
    else $error("done longer than one cycle");

  actual_track_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_DECIDE) |=> o_actual == 32'($past(cmp_val)))
    else $error("actual value not updated with decision");

  ext_on_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_SCALE && ctrl[`ATC_CTRL_ONSRC_BIT]) |=> eff_on == WIDE_W'($past(i_ext_on)))
    else $error("on threshold not taken from outside");

  ext_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (state == ATC_SCALE && ctrl[`ATC_CTRL_OFFSRC_BIT]) |=> eff_off == WIDE_W'($past(i_ext_off)))
    else $error("off threshold not taken from outside");

  gain_range_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (gain <= $signed(`ATC_GAIN_MAX)) && (gain >= -$signed(`ATC_GAIN_MAX)))
    else $error("gain out of range");

  thr_range_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (thr_on <= $signed(`ATC_THR_MAX)) && (thr_on >= -$signed(`ATC_THR_MAX)) &&
    (thr_off <= $signed(`ATC_THR_MAX)) && (thr_off >= -$signed(`ATC_THR_MAX)))
    else $error("threshold out of range");

  offs_range_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (offs <= $signed(`ATC_OFFS_MAX)) && (offs >= -$signed(`ATC_OFFS_MAX)))
    else $error("offset out of range");

endmodule : atc_core

//--- rtl/atc_scaler.sv
// Gain and offset scaling of one raw analog value
`timescale 1ns/100ps
`include "atc_regs.svh"
module atc_scaler
  import atc_pkg::*;
#(
  parameter int IN_W = 16,
  parameter int OUT_W = 32
)
(
  input wire logic signed [IN_W-1:0] i_raw,
  input wire logic signed [15:0] i_gain,
  input wire logic signed [15:0] i_offset,
  output logic signed [OUT_W-1:0] o_value
);

  // ===========================================================
  // Scaling
  logic signed [OUT_W-1:0] product;
  logic signed [OUT_W-1:0] quotient;

  always_comb
  begin
    // Gain carries two fraction digits; product then rescaled
    product = OUT_W'(i_raw) * OUT_W'(i_gain);
    quotient = product / $signed(OUT_W'(`ATC_GAIN_SCALE));
    o_value = quotient + OUT_W'(i_offset);
  end

endmodule : atc_scaler

//--- shared/atc_pkg.sv
// Types for the analog threshold block
package atc_pkg;

  typedef enum logic [1:0]
  {
    ATC_IDLE,
    ATC_SCALE,
    ATC_DECIDE
  } atc_state_t;

  typedef enum logic
  {
    ATC_MODE_COMPARE,
    ATC_MODE_TRIGGER
  } atc_mode_t;

endpackage : atc_pkg

//--- shared/atc_regs.svh
// Register offsets, field positions, reset values and limits for the analog threshold block
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// Register offsets (word addresses on the plain port)
`define ATC_CTRL_ADDR 4'h0
`define ATC_GAIN_ADDR 4'h1
`define ATC_OFFS_ADDR 4'h2
`define ATC_ON_ADDR 4'h3
`define ATC_OFF_ADDR 4'h4
`define ATC_STAT_ADDR 4'h5
`define ATC_ACT_ADDR 4'h6
`define ATC_REF_ADDR 4'h7
`define ATC_DIFF_ADDR 4'h8

// Control field positions
`define ATC_CTRL_MODE_BIT 0
`define ATC_CTRL_ONSRC_BIT 1
`define ATC_CTRL_OFFSRC_BIT 2
`define ATC_CTRL_SELA_LSB 4
`define ATC_CTRL_SELB_LSB 8
`define ATC_CTRL_DEC_LSB 12

// Reset values
`define ATC_CTRL_RST 16'h0000
`define ATC_GAIN_RST 16'h0064
`define ATC_OFFS_RST 16'h0000
`define ATC_ON_RST 16'h0000
`define ATC_OFF_RST 16'h0000

// Limits
`define ATC_GAIN_MAX 16'h03E8
`define ATC_OFFS_MAX 16'h2710
`define ATC_THR_MAX 16'h4E20
`define ATC_ADC_MAX 16'h03E8
`define ATC_GAIN_SCALE 32'h00000064

`endif

//--- testbench/atc_src_model.sv
// Model of the raw analog sources feeding the core
`timescale 1ns/100ps
module atc_src_model
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [3:0] i_idx,
  input wire logic [15:0] i_val,
  output logic [127:0] o_analog_channels,
  output logic [31:0] o_analog_outputs
);
  // ==========
  // Source values
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_analog_channels <= '0;
      o_analog_outputs <= '0;
    end
    else if (i_load && i_idx < 4'h8)
    begin
      o_analog_channels[i_idx*16+:16] <= i_val;
    end
    else if (i_load)
    begin
      o_analog_outputs[i_idx[0]*16+:16] <= i_val;
    end
  end
endmodule : atc_src_model

//--- testbench/tb_top.sv
// Self-checking bench for the analog threshold core
`timescale 1ns/100ps
`include "atc_regs.svh"
module tb_top;
  logic clk, rst, tick, wr, rd, ld, q, done;
  logic [3:0] addr, idx;
  logic [15:0] wdata, val, rdata;
  logic [127:0] chans;
  logic [31:0] aouts;
  logic signed [31:0] ext_on, ext_off, act;
  int n_errors, check_count, gain, offs, sa, sb, trig;

  atc_src_model atc_src_model_i (.i_clk(clk), .i_sys_rst(rst), .i_load(ld), .i_idx(idx), .i_val(val),
    .o_analog_channels(chans), .o_analog_outputs(aouts));
  atc_core atc_core_i (.i_clk(clk), .i_sys_rst(rst), .i_cycle_tick(tick), .i_analog_channels(chans),
    .i_analog_outputs(aouts), .i_ext_on(ext_on), .i_ext_off(ext_off), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_q(q), .o_actual(act), .o_done(done));

  // ==========
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========
  // Tasks
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  function automatic int sc(input int r);
    return r * gain / 100 + offs;
  endfunction : sc

  task automatic wr_reg(input logic [3:0] a, input int v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= 16'(v);
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_check(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rdata", rdata, e);
  endtask : rd_check

  task automatic set_src(input int i, input int v);
    @(posedge clk);
    ld <= 1'b1;
    idx <= 4'(i);
    val <= 16'(v);
    @(posedge clk);
    ld <= 1'b0;
  endtask : set_src

  task automatic setup(input logic [15:0] c, input int g, input int o, input int on, input int off);
    wr_reg(`ATC_CTRL_ADDR, c);
    wr_reg(`ATC_GAIN_ADDR, g);
    wr_reg(`ATC_OFFS_ADDR, o);
    wr_reg(`ATC_ON_ADDR, on);
    wr_reg(`ATC_OFF_ADDR, off);
    gain = g;
    offs = o;
    sa = c[7:4];
    sb = c[11:8];
    trig = c[0];
  endtask : setup

  task automatic eval(input int a, input int b, input logic eq);
    int k;
    int e;
    set_src(sa, a);
    if (trig == 0)
      set_src(sb, b);
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    for (k = 0; k < 10 && done !== 1'b1; k++)
    begin
      @(posedge clk);
      #1;
    end
    if (k == 10)
    begin
      n_errors++;
      report_and_stop();
    end
    e = sc(a) - ((trig != 0) ? 0 : sc(b));
    check("latency", k, 2);
    check("q", q, eq);
    check("actual", act, e);
    @(posedge clk);
    #1;
    check("done", done, 1'b0);
  endtask : eval

  // ==========
  // Main sequence
  initial
  begin
    {rst, tick, wr, rd, ld} = 5'h10;
    {addr, idx, wdata, val} = '0;
    ext_on = '0;
    ext_off = '0;
    {n_errors, check_count, gain, offs, sa, sb, trig} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_check(`ATC_CTRL_ADDR, 16'h0000);
    rd_check(`ATC_GAIN_ADDR, 16'h0064);
    rd_check(`ATC_OFFS_ADDR, 16'h0000);
    rd_check(`ATC_ON_ADDR, 16'h0000);
    rd_check(`ATC_OFF_ADDR, 16'h0000);
    rd_check(4'hF, 16'h0000);
    wr_reg(`ATC_GAIN_ADDR, 2000);
    rd_check(`ATC_GAIN_ADDR, 16'h03E8);
    wr_reg(`ATC_GAIN_ADDR, -2000);
    rd_check(`ATC_GAIN_ADDR, 16'hFC18);
    wr_reg(`ATC_OFFS_ADDR, 12000);
    rd_check(`ATC_OFFS_ADDR, 16'h2710);
    wr_reg(`ATC_ON_ADDR, 30000);
    rd_check(`ATC_ON_ADDR, 16'h4E20);
    wr_reg(`ATC_OFF_ADDR, -30000);
    rd_check(`ATC_OFF_ADDR, 16'hB1E0);
    $display("register test done");
    setup(16'h3700, -150, 25, 200, 100);
    eval(0, 200, 1'b1);
    rd_check(`ATC_ACT_ADDR, 16'h0019);
    rd_check(`ATC_STAT_ADDR, 16'h0003);
    rd_check(`ATC_REF_ADDR, 16'hFEED);
    rd_check(`ATC_DIFF_ADDR, 16'h012C);
    eval(0, 133, 1'b1);
    eval(0, 68, 1'b1);
    eval(0, 67, 1'b0);
    eval(0, 68, 1'b0);
    eval(0, 134, 1'b1);
    $display("comparator hysteresis test done");
    setup(16'h0930, 100, 0, -50, 50);
    eval(100, 151, 1'b0);
    eval(100, 150, 1'b1);
    eval(149, 100, 1'b1);
    eval(150, 100, 1'b0);
    rd_check(`ATC_STAT_ADDR, 16'h0000);
    $display("comparator window test done");
    setup(16'h0081, 1000, -10000, 0, -5000);
    eval(1000, 0, 1'b0);
    eval(1001, 0, 1'b1);
    eval(600, 0, 1'b1);
    eval(500, 0, 1'b0);
    eval(501, 0, 1'b0);
    $display("trigger hysteresis test done");
    setup(16'h0021, 100, 0, 10, 20);
    eval(9, 0, 1'b0);
    eval(10, 0, 1'b1);
    eval(19, 0, 1'b1);
    eval(20, 0, 1'b0);
    $display("trigger window test done");
    @(posedge clk);
    ext_on <= 300;
    ext_off <= 100;
    setup(16'h0027, 100, 0, 10, 20);
    eval(301, 0, 1'b1);
    eval(200, 0, 1'b1);
    eval(100, 0, 1'b0);
    $display("external threshold test done");
    report_and_stop();
  end
endmodule : tb_top
